/* File: bscmd_pkg.sv */
// Purpose: Shared constants and types for the bridge SPI command map block
// Assumes: 6-bit instruction codes, 8-bit registers, 16-clock SPI frames
// Notes: Identity and revision values are parameters of the top module
package bscmd_pkg;
   // Six-bit instruction codes, bit 5 set for writes
   localparam logic [5:0] CMD_READ_IDENTITY_CMD = 6'h04;
   localparam logic [5:0] CMD_RD_REV = 6'h06;
   localparam logic [5:0] CMD_RD_FP = 6'h10;
   localparam logic [5:0] CMD_RD_FH = 6'h18;
   localparam logic [5:0] CMD_RD_CFG = 6'h08;
   localparam logic [5:0] CMD_RD_SM = 6'h0c;
   localparam logic [5:0] CMD_RD_XI = 6'h0e;
   localparam logic [5:0] CMD_WR_FP = 6'h30;
   localparam logic [5:0] CMD_WR_FH = 6'h38;
   localparam logic [5:0] CMD_WR_CFG = 6'h28;
   localparam logic [5:0] CMD_WR_SM = 6'h2c;
   localparam logic [5:0] CMD_WR_XI = 6'h2e;
   // Fault codes
   localparam logic [3:0] FC_GND1 = 4'h1;
   localparam logic [3:0] FC_GND2 = 4'h2;
   localparam logic [3:0] FC_BAT1 = 4'h5;
   localparam logic [3:0] FC_BAT2 = 4'h6;
   localparam logic [3:0] FC_OVLD = 4'h7;
   localparam logic [3:0] FC_BAT_DIS = 4'h8;
   localparam logic [3:0] FC_GND_DIS = 4'h9;
   localparam logic [3:0] FC_OPEN = 4'ha;
   localparam logic [3:0] FC_UNDERV = 4'hd;
   localparam logic [3:0] FC_NONE = 4'hf;
   // Field positions and reset values
   localparam int BIT_DIS = 7;
   localparam int BIT_OT = 6;
   localparam int BIT_CLR = 0;
   localparam logic [7:0] CFG_RST = 8'hfa;
   localparam logic [7:0] SM_RST = 8'h01;
   localparam logic [7:0] XI_RST = 8'h00;
   localparam logic [7:0] FH_RST = 8'hff;
   localparam logic [5:0] CHECK_FIX = 6'h2a;
   localparam logic [7:0] DATA_BAD = 8'hff;
   localparam logic [4:0] FRAME_BITS = 5'd16;
   // Fault event inputs
   typedef struct packed {
      logic ground_short_out_one;
      logic ground_short_out_two;
      logic battery_short_out_one;
      logic battery_short_out_two;
      logic short_over_load;
      logic battery_short_disabled;
      logic ground_short_disabled;
      logic open_load;
   } bscmd_fault_t;
   // Completed frame handed from link domain
   typedef struct packed {
      logic [7:0] inst;
      logic [7:0] data;
      logic bad_len;
   } bscmd_frame_t;
endpackage : bscmd_pkg

/* File: bscmd_top.sv */
// Purpose: SPI command decoder and register bank of an H-bridge driver
// Assumes: SCK idles low; shift on SCK domain, registers on sys_clk
// Notes: Answers lag one frame; link and register sides meet through a toggle
// Function
// - 010000 reads primary diagnosis; 110000 writes are accepted but change nothing
// - 011000 reads, 111000 writes fault history
// - 001100 reads, 101100 writes supply monitor
// - 001110 reads, 101110 writes extra info
// - Unknown codes set the transfer failure flag
// - Identity register returns fixed 8-bit code
// - Revision: software 7:4, mask 3:0
// - Bit 6 low on overheat; 5:4 zero
// - Latch ground, battery and overload short codes
// - Latch 1000/1001 for disabled-output shorts
// - Latch 1010 open load; 1111 no failure
// - Undervoltage 1101 unlatched; blocks clear while present
// - Reads leave primary diagnosis unchanged
// - Clear bit zero moves faults to history
`timescale 1ns/10ps
module bscmd_top #(
   parameter logic [7:0] ID_CODE = 8'h5a, // Arbitrary value
   parameter logic [3:0] SW_REV = 4'h3, // Arbitrary value
   parameter logic [3:0] MASK_REV = 4'h2 // Arbitrary value
) (
   // System
   input wire logic sys_clk,
   input wire logic rst_n,
   // SPI link
   input wire logic spi_sck,
   input wire logic spi_ss_n,
   input wire logic spi_si,
   output logic spi_so,
   output logic spi_so_oe,
   // Bridge status pins
   input wire logic active_low_bridge_enable,
   input wire logic bridge_disable,
   input wire logic overheat_in,
   input wire logic supply_undervoltage,
   input wire bscmd_pkg::bscmd_fault_t fault_in,
   // Register views
   output logic [7:0] config_q,
   output logic [7:0] fault_primary_q,
   output logic [7:0] fault_history_q,
   output logic transfer_failure_flag
);
   import bscmd_pkg::*;

   // Link domain: shift register, bit count, toggle for completed frames
   logic [15:0] sh_q; // Received bits, MSB first
   logic [4:0] cnt_q; // Edges seen in frame
   logic [7:0] tx_q; // Outgoing byte
   logic tg_q; // Frame-done toggle
   bscmd_frame_t frm_q; // Held frame, stable when toggle flips
   logic [7:0] rsp_q; // Data byte answer prepared by sys domain
   logic chk_q; // Failure bit for check byte, sys domain

   // Sample SI on falling SCK; frame ends on SS rise via async reset
   // The count saturates, so an overlong frame still reads as a bad length
   always_ff @(negedge spi_sck or posedge spi_ss_n) begin
      if (spi_ss_n) begin
         cnt_q <= 5'd0;
         sh_q <= 16'h0000;
      end else begin
         sh_q <= {sh_q[14:0], spi_si};
         if (cnt_q != 5'h1f) begin
            cnt_q <= cnt_q + 5'd1;
         end
      end
   end

   // SS rise captures the frame and flips the toggle; contents settle first
   always_ff @(posedge spi_ss_n or negedge rst_n) begin
      if (!rst_n) begin
         tg_q <= 1'b0;
         frm_q <= '0;
      end else begin
         tg_q <= ~tg_q;
         frm_q.inst <= sh_q[15:8];
         frm_q.data <= sh_q[7:0];
         frm_q.bad_len <= (cnt_q != FRAME_BITS);
      end
   end

   // Shift out on rising SCK: check byte, then answer; rsp and chk are quasi-static
   always_ff @(posedge spi_sck or posedge spi_ss_n) begin
      if (spi_ss_n) begin
         tx_q <= 8'h00;
         spi_so_oe <= 1'b0;
         spi_so <= 1'b0;
      end else if (cnt_q == 5'd0) begin
         // Bit 7 of the check byte leaves now, so tx_q keeps only bits 6:0
         tx_q <= {1'b0, CHECK_FIX[5:1], chk_q, 1'b0};
         spi_so <= 1'b0;
         spi_so_oe <= 1'b0; // Top two check bits float
      end else if (cnt_q == 5'd8) begin
         tx_q <= {rsp_q[6:0], 1'b0};
         spi_so <= rsp_q[7];
         spi_so_oe <= 1'b1;
      end else begin
         tx_q <= {tx_q[6:0], 1'b0};
         spi_so <= tx_q[7];
         spi_so_oe <= (cnt_q >= 5'd2);
      end
   end

   // Toggle synchroniser; first stage read only by second
   // Third stage only marks the edge; frm_q has long been stable by then
   logic tg_s1_q, tg_s2_q, tg_s3_q;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tg_s1_q <= 1'b0;
         tg_s2_q <= 1'b0;
         tg_s3_q <= 1'b0;
      end else begin
         tg_s1_q <= tg_q;
         tg_s2_q <= tg_s1_q;
         tg_s3_q <= tg_s2_q;
      end
   end
   logic frame_done;
   assign frame_done = tg_s2_q ^ tg_s3_q;

   // Status pins from outside the domain pass two flops
   // Packing order here must match the unpacking below
   logic [11:0] pin_s1_q, pin_s2_q;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_q <= 12'h000;
         pin_s2_q <= 12'h000;
      end else begin
         pin_s1_q <= {active_low_bridge_enable, bridge_disable, overheat_in,
                      supply_undervoltage, fault_in};
         pin_s2_q <= pin_s1_q;
      end
   end
   logic abe_s, dis_s, ot_s, uv_s;
   bscmd_fault_t flt_s;
   assign {abe_s, dis_s, ot_s, uv_s, flt_s} = pin_s2_q;

   // Enable-disable reset event: bridge becomes enabled
   // en_q resets low, so a bridge enabled at power-up also gives one event
   logic en_q;
   logic en_now;
   assign en_now = abe_s && !dis_s;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         en_q <= 1'b0;
      end else begin
         en_q <= en_now;
      end
   end
   logic enable_disable_reset_event;
   assign enable_disable_reset_event = en_now && !en_q;

   // Decode the held frame
   // Chip address bits other than 00 refuse the frame like an unknown code
   logic [5:0] cmd;
   logic known, is_wr, bad;
   assign cmd = frm_q.inst[5:0];
   always_comb begin
      unique case (cmd)
         CMD_READ_IDENTITY_CMD, CMD_RD_REV, CMD_RD_FP, CMD_RD_FH, CMD_RD_CFG, CMD_RD_SM,
         CMD_RD_XI, CMD_WR_FP, CMD_WR_FH, CMD_WR_CFG, CMD_WR_SM,
         CMD_WR_XI: known = 1'b1;
         default: known = 1'b0;
      endcase
   end
   assign is_wr = cmd[5];
   assign bad = !known || frm_q.bad_len || (frm_q.inst[7:6] != 2'b00);
   logic wr_ok;
   assign wr_ok = frame_done && !bad && is_wr;

   // Supply monitor control register; clear bit written zero is a request
   // The clear bit always reads back one, so a read-modify-write never re-clears
   logic [7:0] sm_q;
   logic clr_req;
   assign clr_req = wr_ok && (cmd == CMD_WR_SM) && !frm_q.data[BIT_CLR];
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sm_q <= SM_RST;
      end else if (wr_ok && cmd == CMD_WR_SM) begin
         sm_q <= frm_q.data | SM_RST; // Clear bit reads back as one
      end
   end

   // Config and extra-info registers
   logic [7:0] xi_q;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         config_q <= CFG_RST;
         xi_q <= XI_RST;
      end else begin
         if (wr_ok && cmd == CMD_WR_CFG) begin
            config_q <= frm_q.data;
         end
         if (wr_ok && cmd == CMD_WR_XI) begin
            xi_q <= frm_q.data;
         end
      end
   end

   // Fault latch: first fault wins until cleared
   // Faults and overheat are latched; undervoltage is merged later so it never sticks
   logic [3:0] code_q;
   logic [3:0] new_code;
   always_comb begin
      new_code = FC_NONE;
      if (flt_s.ground_short_out_one) new_code = FC_GND1;
      else if (flt_s.ground_short_out_two) new_code = FC_GND2;
      else if (flt_s.battery_short_out_one) new_code = FC_BAT1;
      else if (flt_s.battery_short_out_two) new_code = FC_BAT2;
      else if (flt_s.short_over_load) new_code = FC_OVLD;
      else if (flt_s.battery_short_disabled) new_code = FC_BAT_DIS;
      else if (flt_s.ground_short_disabled) new_code = FC_GND_DIS;
      else if (flt_s.open_load) new_code = FC_OPEN;
   end
   logic do_clr;
   assign do_clr = clr_req && !uv_s;
   logic ot_latch_q;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         code_q <= FC_NONE;
         ot_latch_q <= 1'b1;
      end else begin
         // Set wins over clear for overheat and an empty latch; a clear drops a new fault while a code is held
         if (code_q == FC_NONE && new_code != FC_NONE) begin
            code_q <= new_code;
         end else if (do_clr || enable_disable_reset_event) begin
            code_q <= FC_NONE;
         end
         if (ot_s) begin
            ot_latch_q <= 1'b0;
         end else if (do_clr || enable_disable_reset_event) begin
            ot_latch_q <= 1'b1;
         end
         // Reads do not touch the latch
      end
   end

   // Visible primary register; undervoltage overrides the code unlatched
   logic [7:0] fp_d;
   always_comb begin
      fp_d = {en_now, ot_latch_q, 2'b00, code_q};
      if (uv_s) fp_d[3:0] = FC_UNDERV;
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_primary_q <= {1'b0, 1'b1, 2'b00, FC_NONE};
      end else begin
         fault_primary_q <= fp_d;
      end
   end

   // History register takes latched errors on clear, or a direct write
   // A clear and a direct write never meet, as they need different commands
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_history_q <= FH_RST;
      end else if (do_clr) begin
         fault_history_q <= {fault_history_q[7:6], ot_latch_q, 1'b0, code_q};
      end else if (wr_ok && cmd == CMD_WR_FH) begin
         fault_history_q <= frm_q.data;
      end
   end

   // Answer byte for the next frame and failure flag
   logic [7:0] rd_d;
   always_comb begin
      case (cmd)
         CMD_READ_IDENTITY_CMD: rd_d = ID_CODE;
         CMD_RD_REV: rd_d = {SW_REV, MASK_REV};
         CMD_RD_FP: rd_d = fault_primary_q;
         CMD_RD_FH: rd_d = fault_history_q;
         CMD_RD_CFG: rd_d = config_q;
         CMD_RD_SM: rd_d = sm_q;
         CMD_RD_XI: rd_d = xi_q;
         default: rd_d = 8'h00;
      endcase
   end
   // The answer lags one frame: a read is served in the following frame's data byte
   // rsp_q and chk_q cross to the link as quasi-static words: they settle a few sys_clk
   // after SS rises, so the host must leave the idle gap before its next frame
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_q <= 8'h00;
         transfer_failure_flag <= 1'b0;
      end else if (frame_done) begin
         rsp_q <= bad ? DATA_BAD : (is_wr ? 8'h00 : rd_d);
         transfer_failure_flag <= bad;
      end
   end
   assign chk_q = transfer_failure_flag;

   // Writes to the primary register are accepted but change nothing

   // Register-side checks on sys_clk; link timing is checked by the bench
   a_bad_sets_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
      frame_done && bad |=> transfer_failure_flag) else $error("bad code not flagged");
   a_bad_answer: assert property (@(posedge sys_clk) disable iff (!rst_n)
      frame_done && bad |=> rsp_q == DATA_BAD) else $error("bad code answered");
   a_bad_keep: assert property (@(posedge sys_clk) disable iff (!rst_n)
      frame_done && bad |=> $stable(config_q) && $stable(xi_q))
      else $error("refused frame changed a register");
   a_wr_cfg: assert property (@(posedge sys_clk) disable iff (!rst_n)
      wr_ok && cmd == CMD_WR_CFG |=> config_q == $past(frm_q.data))
      else $error("config write lost");
   a_uv_blocks_clr: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clr_req && uv_s |=> $stable(fault_history_q)) else $error("clear under uv");
   a_uv_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
      uv_s |=> fault_primary_q[3:0] == FC_UNDERV) else $error("uv code wrong");
   a_res_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      fault_primary_q[5:4] == 2'b00) else $error("reserved bits set");
   a_ot_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
      ot_s |=> ##1 !fault_primary_q[BIT_OT]) else $error("overheat not shown");
   a_dis_bit: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !abe_s |=> !fault_primary_q[BIT_DIS]) else $error("disable not shown");
   // A held code may only move on a clear or an enable-disable reset
   a_latch_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      code_q != FC_NONE && !do_clr && !enable_disable_reset_event |=> $stable(code_q))
      else $error("fault code lost");
   a_clr_copy: assert property (@(posedge sys_clk) disable iff (!rst_n)
      do_clr |=> fault_history_q[3:0] == $past(code_q)) else $error("history copy");
   a_clr_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
      do_clr && new_code == FC_NONE |=> code_q == FC_NONE && ot_latch_q == !$past(ot_s))
      else $error("clear not reset");
   a_id_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
      frame_done && !bad && cmd == CMD_READ_IDENTITY_CMD |=> rsp_q == ID_CODE)
      else $error("identity wrong");
   a_rev_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
      frame_done && !bad && cmd == CMD_RD_REV |=> rsp_q == {SW_REV, MASK_REV})
      else $error("revision wrong");
   a_first_fault: assert property (@(posedge sys_clk) disable iff (!rst_n)
      code_q == FC_NONE && new_code == FC_GND1 |=> code_q == FC_GND1)
      else $error("fault not latched");

   // Main scenarios reached by the bench
   c_clear: cover property (@(posedge sys_clk) disable iff (!rst_n) do_clr);
   c_bad: cover property (@(posedge sys_clk) disable iff (!rst_n) frame_done && bad);
   c_read_fp: cover property (@(posedge sys_clk) disable iff (!rst_n)
      frame_done && cmd == CMD_RD_FP);
   c_uv_clear: cover property (@(posedge sys_clk) disable iff (!rst_n) clr_req && uv_s);
   c_en_reset: cover property (@(posedge sys_clk) disable iff (!rst_n)
      enable_disable_reset_event);
endmodule : bscmd_top

/* File: bscmd_host_model.sv */
// Purpose: SPI host model that clocks whole frames into the command map
// Assumes: SCK idles low with a 64 ns period and runs only inside a frame
// Notes: SI shows the inverse of its last bit once the frame is over
`timescale 1ns/10ps
module bscmd_host_model (
   // Lines driven by the host
   output logic sck,
   output logic ss_n,
   output logic si,
   // Lines driven by the device
   input wire logic so,
   input wire logic so_oe
);
   // Idle levels; SS starts low for 1 ns so that its rise clears the link logic
   initial begin
      sck = 1'b0;
      ss_n = 1'b0;
      si = 1'b0;
      #1 ss_n = 1'b1;
   end
   // One 16-clock frame, MSB first; rx gets SO, en gets its drive flag
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx,
                       output logic [15:0] en);
      #7 ss_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         // SI moves 1 ns after the last fall, never in the sampling time step
         #1 si = tx[i];
         #31 sck = 1'b1;
         // SO moved on the rise; take it just before the fall
         #31 rx[i] = so;
         en[i] = so_oe;
         #1 sck = 1'b0;
      end
      // A released SI must not look like a held value
      #16 si = ~si;
      #16 ss_n = 1'b1;
      // Gap well above the 30 ns the device needs between frames
      #100;
   endtask : xfer
endmodule : bscmd_host_model

/* File: test_bridge_spi_command_map_diag.sv */
// Purpose: Self-checking bench for the bridge SPI command map
// Assumes: Answers arrive one frame late, fetched with an identity read
// Notes: Pin inputs change 1 ns after a sys_clk rise
`timescale 1ns/10ps
module test_bridge_spi_command_map_diag;
   import bscmd_pkg::*;
   // Clock, reset and pins
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic en_pin = 1'b1;
   logic dis = 1'b0;
   logic ot = 1'b0;
   logic uv = 1'b0;
   bscmd_fault_t fault = '0;
   // SPI wires and register views
   logic spi_sck, spi_ss_n, spi_si, spi_so, spi_so_oe, tf;
   logic [7:0] cfg, fp, fh;
   int fail_count = 0;
   int total_checks = 0;
   logic [7:0] codes [8] = '{FC_GND1, FC_GND2, FC_BAT1, FC_BAT2, FC_OVLD,
                             FC_BAT_DIS, FC_GND_DIS, FC_OPEN};
   logic [7:0] bad [4] = '{8'h00, 8'h3f, 8'h11, 8'h68};
   always #5 sys_clk = ~sys_clk;
   bscmd_top i_bscmd_top (.sys_clk(sys_clk), .rst_n(rst_n), .spi_sck(spi_sck),
      .spi_ss_n(spi_ss_n), .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe),
      .active_low_bridge_enable(en_pin), .bridge_disable(dis), .overheat_in(ot),
      .supply_undervoltage(uv), .fault_in(fault), .config_q(cfg),
      .fault_primary_q(fp), .fault_history_q(fh), .transfer_failure_flag(tf));
   bscmd_host_model i_bscmd_host_model (.sck(spi_sck), .ss_n(spi_ss_n),
      .si(spi_si), .so(spi_so), .so_oe(spi_so_oe));
   // Byte compare, counted
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check8
   // Frame with inst and data, then a fetch frame that carries its answer
   task automatic op(input logic [7:0] inst, input logic [7:0] data,
                     input logic [7:0] ans, input logic flag);
      logic [15:0] rx;
      logic [15:0] en;
      i_bscmd_host_model.xfer({inst, data}, rx, en);
      i_bscmd_host_model.xfer({2'b00, CMD_READ_IDENTITY_CMD, 8'h00}, rx, en);
      // Top two check bits undriven, then the fixed pattern and the flag
      check8({en[15:14], rx[13:9], 1'b0}, {2'b00, 5'b10101, 1'b0});
      check8({7'h00, rx[8]}, {7'h00, flag});
      check8(rx[7:0], ans);
   endtask : op
   // Set the pins just after an edge, then let the synchronisers settle
   task automatic pins(input logic e, input logic d, input logic o, input logic u,
                       input logic [7:0] f);
      @(posedge sys_clk);
      #1 en_pin = e;
      dis = d;
      ot = o;
      uv = u;
      fault = f;
      repeat (8) @(posedge sys_clk);
      #1;
   endtask : pins
   // Closing report
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict
   // Hang guard, generous against about 100 us of frames
   initial begin
      #400000;
      fail_count++;
      give_verdict();
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      check8(cfg, CFG_RST);
      check8(fh, FH_RST);
      check8({7'h00, tf}, 8'h00);
      repeat (4) @(posedge sys_clk);
      #1;
      check8(fp, 8'hcf); // Primary view out of reset
      op({2'b00, CMD_READ_IDENTITY_CMD}, 8'h00, 8'h5a, 1'b0); // Identity
      op({2'b00, CMD_RD_REV}, 8'h00, 8'h32, 1'b0); // Revision
      op({2'b00, CMD_RD_CFG}, 8'h00, CFG_RST, 1'b0);
      op({2'b00, CMD_WR_CFG}, 8'h5c, 8'h00, 1'b0);
      check8(cfg, 8'h5c); // Config stored
      op({2'b00, CMD_RD_CFG}, 8'h00, 8'h5c, 1'b0);
      op({2'b00, CMD_WR_XI}, 8'h3c, 8'h00, 1'b0);
      op({2'b00, CMD_RD_XI}, 8'h00, 8'h3c, 1'b0);
      op({2'b00, CMD_WR_SM}, 8'ha5, 8'h00, 1'b0);
      op({2'b00, CMD_RD_SM}, 8'h00, 8'ha5, 1'b0);
      op({2'b00, CMD_RD_FH}, 8'h00, FH_RST, 1'b0);
      op({2'b00, CMD_WR_FH}, 8'hff, 8'h00, 1'b0);
      op({2'b00, CMD_WR_FP}, 8'h00, 8'h00, 1'b0);
      op({2'b00, CMD_RD_FP}, 8'h00, 8'hcf, 1'b0);
      // Unused codes and a config write to a foreign chip address are refused
      foreach (bad[i]) op(bad[i], 8'h77, 8'hff, 1'b1);
      check8(cfg, 8'h5c); // Nothing changed by refusals
      // Each fault latches its code, survives reads, moves on clear
      for (int i = 0; i < 8; i++) begin
         pins(1'b1, 1'b0, 1'b0, 1'b0, 8'h80 >> i);
         pins(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
         op({2'b00, CMD_RD_FP}, 8'h00, {4'hc, codes[i][3:0]}, 1'b0);
         op({2'b00, CMD_RD_FP}, 8'h00, {4'hc, codes[i][3:0]}, 1'b0);
         op({2'b00, CMD_WR_SM}, 8'ha4, 8'h00, 1'b0); // Clear request
         check8({4'h0, fh[3:0]}, codes[i]); // History copy
         check8(fp, 8'hcf); // Primary cleared
      end
      // Overheat latches low; disable and enable reset clear it
      pins(1'b1, 1'b0, 1'b1, 1'b0, 8'h01);
      pins(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
      check8(fp, 8'h8a);
      pins(1'b1, 1'b1, 1'b0, 1'b0, 8'h00);
      check8(fp, 8'h0a); // Bridge off by disable
      pins(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
      check8(fp, 8'hcf); // Re-enable resets code and overheat
      pins(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
      check8(fp, 8'h4f); // Bridge off by enable pin
      pins(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
      // Undervoltage shows unlatched and holds off a clear
      pins(1'b1, 1'b0, 1'b0, 1'b1, 8'h00);
      check8(fp, {4'hc, FC_UNDERV});
      pins(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
      check8(fp, 8'hcf); // Not latched
      pins(1'b1, 1'b0, 1'b0, 1'b0, 8'h80);
      pins(1'b1, 1'b0, 1'b0, 1'b1, 8'h00);
      op({2'b00, CMD_WR_SM}, 8'ha4, 8'h00, 1'b0);
      pins(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
      check8(fp, 8'hc1); // Clear refused under undervoltage
      op({2'b00, CMD_WR_SM}, 8'ha4, 8'h00, 1'b0);
      check8(fp, 8'hcf);
      give_verdict();
   end
endmodule : test_bridge_spi_command_map_diag
